//--- common/tcc_pkg.sv
// Package with register map, field layout, reset values and carrier types for the timing core.
package tcc_pkg;

   // Register offsets on the serial register port.
   localparam logic [7:0] TCC_OFS_INT_MASK   = 8'h01;
   localparam logic [7:0] TCC_OFS_RATIO      = 8'h0A;
   localparam logic [7:0] TCC_OFS_SAMP_FREQ  = 8'h12;
   localparam logic [7:0] TCC_OFS_AVG        = 8'h15;
   localparam logic [7:0] TCC_OFS_PULSE_A    = 8'h31;
   localparam logic [7:0] TCC_OFS_PULSE_B    = 8'h36;
   localparam logic [7:0] TCC_OFS_APWR       = 8'h3C;
   localparam logic [7:0] TCC_OFS_SLOW_TRIM  = 8'h4B;
   localparam logic [7:0] TCC_OFS_FAST_TRIM  = 8'h4D;
   localparam logic [7:0] TCC_OFS_RATIO_CTL  = 8'h50;

   // Field positions.
   localparam int TCC_BIT_MASK_A      = 5;
   localparam int TCC_BIT_MASK_B      = 6;
   localparam int TCC_BIT_RATIO_EN    = 5;
   localparam int TCC_AVG_A_LSB       = 4;
   localparam int TCC_AVG_B_LSB       = 8;
   localparam int TCC_AVG_W           = 3;
   localparam int TCC_PCOUNT_LSB      = 8;
   localparam int TCC_PCOUNT_W        = 8;
   localparam int TCC_WIDTH_W         = 5;
   localparam int TCC_APWR_LSB        = 3;
   localparam int TCC_APWR_W          = 6;
   localparam int TCC_STRIM_W         = 6;
   localparam int TCC_FTRIM_W         = 8;
   localparam int TCC_RATIO_W         = 12;

   // Analog power field codes.
   localparam logic [5:0] TCC_APWR_ALL_ON  = 6'h00;
   localparam logic [5:0] TCC_APWR_SINGLE  = 6'h38;
   localparam logic [5:0] TCC_APWR_NO_BPF  = 6'h12;

   // Reset values.
   localparam logic [15:0] TCC_RST_INT_MASK  = 16'hFFFF;
   localparam logic [15:0] TCC_RST_SAMP_FREQ = 16'h0020;
   localparam logic [15:0] TCC_RST_AVG       = 16'h0000;
   localparam logic [15:0] TCC_RST_PULSE     = 16'h0104;
   localparam logic [15:0] TCC_RST_ZERO      = 16'h0000;

   // Ratio measurement spans this many slow periods.
   localparam logic [1:0] TCC_RATIO_SLOW_PERIODS = 2'h2;

   // Interrupt pin pulse width.
   localparam int TCC_CLK_MHZ       = 125;
   localparam int TCC_INT_PULSE_NS  = 64;
   localparam int TCC_INT_PULSE_CYC = (TCC_INT_PULSE_NS * TCC_CLK_MHZ) / 1000;

   typedef enum logic [1:0] {TCC_R_IDLE, TCC_R_ARM, TCC_R_COUNT, TCC_R_DONE} tcc_ratio_t;
   typedef enum logic [1:0] {TCC_S_IDLE, TCC_S_SLOT_A, TCC_S_SLOT_B} tcc_seq_t;

   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [7:0]  addr;
      logic [15:0] wdata;
   } tcc_reg_req_t;

   typedef struct packed {
      logic       rvalid;
      logic [15:0] rdata;
   } tcc_reg_rsp_t;

   typedef struct packed {
      logic [TCC_APWR_W-1:0] field;
      logic                  single_chan;
      logic                  bpf_off;
   } tcc_afe_ctrl_t;

endpackage : tcc_pkg

//--- hdl/tcc_timing_core.sv
// Timing core: oscillator trims, clock ratio measurement, sample and pulse scheduling.
`timescale 1ns/1ns

// Operation
// - Sample schedule from slow oscillator; pulses and capture timed by fast oscillator.
// - Unmasked slot sample interrupt pulses the interrupt pin once per sample.
// - Six-bit slow trim field; software steers it until interrupt rate matches.
// - With ratio enable set, count fast cycles over two slow cycles, twelve bits.
// - Clearing ratio enable resets the counter; setting it starts a new measurement.
// - Eight-bit fast trim field; software writes computed error over step size.
// - Emit per-slot LED pulse count from upper byte of each pulse register.
// - Sum a programmable number of internal samples per slot, three-bit field.
// - Output sample rate equals sampling frequency divided by averaging factor.
// - Analog power code 0x38 powers down channels two to four; 0x00 keeps all.
// - Analog power code b010010 disables band-pass filters for digital integrate.
// - Mask bit 5 gates slot A, bit 6 gates slot B; zero enables.
module tcc_timing_core #(
   parameter int INT_PULSE_CYC = tcc_pkg::TCC_INT_PULSE_CYC
) (
   input  wire logic                                core_clk_in,     // 125 MHz core clock
   input  wire logic                                rstn_in,         // Async reset, active low
   input  wire tcc_pkg::tcc_reg_req_t               reg_req_in,      // Register access request
   output      tcc_pkg::tcc_reg_rsp_t               reg_rsp_out,     // Register read answer
   input  wire logic                                slow_osc_in,     // Slow oscillator output
   input  wire logic                                fast_osc_in,     // Fast oscillator output
   output      logic [tcc_pkg::TCC_STRIM_W-1:0]     slow_trim_out,   // Slow oscillator trim
   output      logic [tcc_pkg::TCC_FTRIM_W-1:0]     fast_trim_out,   // Fast oscillator trim
   output      logic                                led_a_out,       // Slot A LED drive
   output      logic                                led_b_out,       // Slot B LED drive
   output      logic                                sample_a_out,    // Slot A output sample strobe
   output      logic                                sample_b_out,    // Slot B output sample strobe
   output      logic                                int_out,         // Interrupt pin, active high
   output      tcc_pkg::tcc_afe_ctrl_t              afe_ctrl_out     // Analog power controls
);
   import tcc_pkg::*;

   typedef struct packed {
      logic [15:0]             int_mask;
      logic [15:0]             samp_freq;
      logic [15:0]             avg;
      logic [15:0]             pulse_a;
      logic [15:0]             pulse_b;
      logic [15:0]             apwr;
      logic [15:0]             strim;
      logic [15:0]             ftrim;
      logic [15:0]             rctl;
      logic [TCC_RATIO_W-1:0]  ratio;
      tcc_ratio_t              rstate;
      logic [1:0]              slow_seen;
      logic [2:0]              slow_sync;
      logic [2:0]              fast_sync;
      logic [15:0]             samp_cnt;
      tcc_seq_t                seq;
      logic [TCC_PCOUNT_W-1:0] pulses_left;
      logic [TCC_WIDTH_W:0]    phase;
      logic [7:0]              avg_cnt_a;
      logic [7:0]              avg_cnt_b;
      logic [7:0]              int_cnt;
      logic                    int_pin;
      logic                    led_a;
      logic                    led_b;
      logic                    samp_a;
      logic                    samp_b;
      tcc_afe_ctrl_t           afe;
      tcc_reg_rsp_t            rsp;
   } tcc_state_t;

   tcc_state_t st_r;
   tcc_state_t st_nxt;

   // Averaging factor is a power of two, 1 to 128.
   function automatic logic [7:0] tcc_avg_n(input logic [TCC_AVG_W-1:0] code);
      tcc_avg_n = 8'h01 << code;
   endfunction : tcc_avg_n

   function automatic logic [15:0] tcc_read(input tcc_state_t s, input logic [7:0] addr);
      tcc_read = 16'h0000;
      unique case (addr)
         TCC_OFS_INT_MASK:  tcc_read = s.int_mask;
         TCC_OFS_RATIO:     tcc_read = {{(16-TCC_RATIO_W){1'b0}}, s.ratio};
         TCC_OFS_SAMP_FREQ: tcc_read = s.samp_freq;
         TCC_OFS_AVG:       tcc_read = s.avg;
         TCC_OFS_PULSE_A:   tcc_read = s.pulse_a;
         TCC_OFS_PULSE_B:   tcc_read = s.pulse_b;
         TCC_OFS_APWR:      tcc_read = s.apwr;
         TCC_OFS_SLOW_TRIM: tcc_read = s.strim;
         TCC_OFS_FAST_TRIM: tcc_read = s.ftrim;
         TCC_OFS_RATIO_CTL: tcc_read = s.rctl;
         default:           tcc_read = 16'h0000;
      endcase
   endfunction : tcc_read

   logic                    slow_rise;
   logic                    fast_rise;
   logic                    ratio_en;
   logic                    sample_tick;
   logic [15:0]             samp_div;
   logic [TCC_PCOUNT_W-1:0] pcount_a;
   logic [TCC_PCOUNT_W-1:0] pcount_b;
   logic [TCC_WIDTH_W-1:0]  emitter_w;
   logic [TCC_WIDTH_W:0]    pulse_period;
   logic                    out_a;
   logic                    out_b;
   logic                    slot_a_emitter_on;
   logic                    slot_b_emitter_on;
   logic [TCC_WIDTH_W-1:0]  slot_a_emitter_width;
   logic [TCC_WIDTH_W-1:0]  slot_b_emitter_width;

   // Edges are taken from the second and third stages only.
   assign slow_rise = st_r.slow_sync[1] & ~st_r.slow_sync[2];
   assign fast_rise = st_r.fast_sync[1] & ~st_r.fast_sync[2];
   assign ratio_en  = st_r.rctl[TCC_BIT_RATIO_EN];
   assign samp_div  = (st_r.samp_freq == 16'h0000) ? 16'h0001 : st_r.samp_freq;
   assign pcount_a  = st_r.pulse_a[TCC_PCOUNT_LSB +: TCC_PCOUNT_W];
   assign pcount_b  = st_r.pulse_b[TCC_PCOUNT_LSB +: TCC_PCOUNT_W];
   assign slot_a_emitter_width = st_r.pulse_a[TCC_WIDTH_W-1:0];
   assign slot_b_emitter_width = st_r.pulse_b[TCC_WIDTH_W-1:0];
   assign emitter_w = (st_r.seq == TCC_S_SLOT_B) ? slot_b_emitter_width : slot_a_emitter_width;
   // A zero width still gives a one-tick pulse; the gap equals the width.
   assign pulse_period = (emitter_w == '0) ? (TCC_WIDTH_W+1)'(2)
                                          : {emitter_w, 1'b0};
   assign sample_tick = slow_rise && (st_r.samp_cnt >= samp_div - 16'h0001);
   assign slot_a_emitter_on = (st_r.seq == TCC_S_SLOT_A) && (st_r.pulses_left != '0)
                              && (st_r.phase < (pulse_period >> 1));
   assign slot_b_emitter_on = (st_r.seq == TCC_S_SLOT_B) && (st_r.pulses_left != '0)
                              && (st_r.phase < (pulse_period >> 1));

   always_comb begin
      st_nxt = st_r;
      out_a  = 1'b0;
      out_b  = 1'b0;

      st_nxt.slow_sync = {st_r.slow_sync[1:0], slow_osc_in};
      st_nxt.fast_sync = {st_r.fast_sync[1:0], fast_osc_in};

      // Register writes; the ratio result is read-only.
      if (reg_req_in.wr) begin
         unique case (reg_req_in.addr)
            TCC_OFS_INT_MASK:  st_nxt.int_mask  = reg_req_in.wdata;
            TCC_OFS_SAMP_FREQ: st_nxt.samp_freq = reg_req_in.wdata;
            TCC_OFS_AVG:       st_nxt.avg       = reg_req_in.wdata;
            TCC_OFS_PULSE_A:   st_nxt.pulse_a   = reg_req_in.wdata;
            TCC_OFS_PULSE_B:   st_nxt.pulse_b   = reg_req_in.wdata;
            TCC_OFS_APWR:      st_nxt.apwr      = reg_req_in.wdata;
            TCC_OFS_SLOW_TRIM: st_nxt.strim     = reg_req_in.wdata;
            TCC_OFS_FAST_TRIM: st_nxt.ftrim     = reg_req_in.wdata;
            TCC_OFS_RATIO_CTL: st_nxt.rctl      = reg_req_in.wdata;
            default: ;
         endcase
      end

      st_nxt.rsp.rvalid = reg_req_in.rd;
      st_nxt.rsp.rdata  = reg_req_in.rd ? tcc_read(st_r, reg_req_in.addr) : 16'h0000;

      if (!ratio_en) begin
         st_nxt.rstate    = TCC_R_IDLE;
         st_nxt.ratio     = '0;
         st_nxt.slow_seen = 2'h0;
      end else begin
         unique case (st_r.rstate)
            TCC_R_IDLE: st_nxt.rstate = TCC_R_ARM;
            TCC_R_ARM: begin
               if (slow_rise) begin
                  st_nxt.rstate    = TCC_R_COUNT;
                  st_nxt.ratio     = '0;
                  st_nxt.slow_seen = 2'h0;
               end
            end
            // count fast edges over two slow periods
            TCC_R_COUNT: begin
               if (slow_rise && (st_r.slow_seen == TCC_RATIO_SLOW_PERIODS - 2'h1)) begin
                  st_nxt.rstate = TCC_R_DONE;
               end else begin
                  if (slow_rise) begin
                     st_nxt.slow_seen = st_r.slow_seen + 2'h1;
                  end
                  if (fast_rise && (st_r.ratio != '1)) begin
                     st_nxt.ratio = st_r.ratio + 1'b1;
                  end
               end
            end
            // hold result until the enable is cleared
            TCC_R_DONE: st_nxt.rstate = TCC_R_DONE;
         endcase
      end

      // sample period counted in slow oscillator edges
      if (slow_rise) begin
         st_nxt.samp_cnt = sample_tick ? 16'h0000 : st_r.samp_cnt + 16'h0001;
      end

      // pulse trains timed by fast oscillator edges
      unique case (st_r.seq)
         TCC_S_IDLE: begin
            if (sample_tick) begin
               st_nxt.seq         = TCC_S_SLOT_A;
               st_nxt.pulses_left = pcount_a;
               st_nxt.phase       = '0;
            end
         end
         TCC_S_SLOT_A, TCC_S_SLOT_B: begin
            if (st_r.pulses_left == '0) begin
               // slot finished: one internal sample taken
               if (st_r.seq == TCC_S_SLOT_A) begin
                  st_nxt.seq         = TCC_S_SLOT_B;
                  st_nxt.pulses_left = pcount_b;
                  st_nxt.phase       = '0;
                  if (st_r.avg_cnt_a >= tcc_avg_n(st_r.avg[TCC_AVG_A_LSB +: TCC_AVG_W])
                                        - 8'h01) begin
                     st_nxt.avg_cnt_a = 8'h00;
                     out_a            = 1'b1;
                  end else begin
                     st_nxt.avg_cnt_a = st_r.avg_cnt_a + 8'h01;
                  end
               end else begin
                  st_nxt.seq = TCC_S_IDLE;
                  if (st_r.avg_cnt_b >= tcc_avg_n(st_r.avg[TCC_AVG_B_LSB +: TCC_AVG_W])
                                        - 8'h01) begin
                     st_nxt.avg_cnt_b = 8'h00;
                     out_b            = 1'b1;
                  end else begin
                     st_nxt.avg_cnt_b = st_r.avg_cnt_b + 8'h01;
                  end
               end
            end else if (fast_rise) begin
               if (st_r.phase >= pulse_period - 1'b1) begin
                  st_nxt.phase       = '0;
                  st_nxt.pulses_left = st_r.pulses_left - 1'b1;
               end else begin
                  st_nxt.phase = st_r.phase + 1'b1;
               end
            end
         end
         default: st_nxt.seq = TCC_S_IDLE;
      endcase

      st_nxt.led_a = slot_a_emitter_on;
      st_nxt.led_b = slot_b_emitter_on;
      // output strobes at sample rate over averaging factor
      st_nxt.samp_a = out_a;
      st_nxt.samp_b = out_b;

      // interrupt pulse per unmasked output sample
      // zero in the mask bit enables that slot
      if ((out_a && !st_r.int_mask[TCC_BIT_MASK_A]) ||
          (out_b && !st_r.int_mask[TCC_BIT_MASK_B])) begin
         st_nxt.int_cnt = 8'(INT_PULSE_CYC);
         st_nxt.int_pin = 1'b1;
      end else if (st_r.int_cnt > 8'h01) begin
         st_nxt.int_cnt = st_r.int_cnt - 8'h01;
      end else begin
         st_nxt.int_cnt = 8'h00;
         st_nxt.int_pin = 1'b0;
      end

      st_nxt.afe.field       = st_r.apwr[TCC_APWR_LSB +: TCC_APWR_W];
      st_nxt.afe.single_chan = (st_r.apwr[TCC_APWR_LSB +: TCC_APWR_W] == TCC_APWR_SINGLE);
      st_nxt.afe.bpf_off     = (st_r.apwr[TCC_APWR_LSB +: TCC_APWR_W] == TCC_APWR_NO_BPF);
   end

   always_ff @(posedge core_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         st_r           <= '0;
         st_r.int_mask  <= TCC_RST_INT_MASK;
         st_r.samp_freq <= TCC_RST_SAMP_FREQ;
         st_r.avg       <= TCC_RST_AVG;
         st_r.pulse_a   <= TCC_RST_PULSE;
         st_r.pulse_b   <= TCC_RST_PULSE;
         st_r.apwr      <= TCC_RST_ZERO;
         st_r.rstate    <= TCC_R_IDLE;
         st_r.seq       <= TCC_S_IDLE;
      end else begin
         st_r <= st_nxt;
      end
   end

   // trims go straight from their registers; no other state is touched by a trim write.
   assign slow_trim_out = st_r.strim[TCC_STRIM_W-1:0];
   assign fast_trim_out = st_r.ftrim[TCC_FTRIM_W-1:0];
   assign led_a_out     = st_r.led_a;
   assign led_b_out     = st_r.led_b;
   assign sample_a_out  = st_r.samp_a;
   assign sample_b_out  = st_r.samp_b;
   assign int_out       = st_r.int_pin;
   assign afe_ctrl_out  = st_r.afe;
   assign reg_rsp_out   = st_r.rsp;

endmodule : tcc_timing_core

//--- tb/tcc_timing_core_properties.sv
// Concurrent checks on the timing core ports.
`timescale 1ns/1ns
module tcc_timing_core_properties #(
   parameter int INT_PULSE_CYC = 8
) (
   input wire logic                                 core_clk_in,   // Core clock
   input wire logic                                 rstn_in,       // Reset, active low
   input wire tcc_pkg::tcc_reg_req_t                reg_req_in,    // Register request
   input wire tcc_pkg::tcc_reg_rsp_t                reg_rsp_out,   // Register answer
   input wire logic                                 slow_osc_in,   // Slow oscillator
   input wire logic                                 fast_osc_in,   // Fast oscillator
   input wire logic [tcc_pkg::TCC_STRIM_W-1:0]      slow_trim_out, // Slow trim
   input wire logic [tcc_pkg::TCC_FTRIM_W-1:0]      fast_trim_out, // Fast trim
   input wire logic                                 led_a_out,     // Slot A emitter
   input wire logic                                 led_b_out,     // Slot B emitter
   input wire logic                                 sample_a_out,  // Slot A strobe
   input wire logic                                 sample_b_out,  // Slot B strobe
   input wire logic                                 int_out,       // Interrupt pin
   input wire tcc_pkg::tcc_afe_ctrl_t               afe_ctrl_out   // Analog controls
);
   import tcc_pkg::*;
   logic [15:0] mask_r;     // Shadow of the interrupt mask
   logic        ratio_en_r; // Shadow of the ratio enable bit
   logic        apwr_wr;    // Write to the analog power register
   assign apwr_wr = reg_req_in.wr && (reg_req_in.addr == TCC_OFS_APWR);
   default clocking cb @(posedge core_clk_in); endclocking
   default disable iff (!rstn_in);
   // Shadows give the checker register state that the ports do not show.
   always_ff @(posedge core_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         mask_r     <= TCC_RST_INT_MASK;
         ratio_en_r <= 1'b0;
      end else if (reg_req_in.wr && reg_req_in.addr == TCC_OFS_INT_MASK) begin
         mask_r <= reg_req_in.wdata;
      end else if (reg_req_in.wr && reg_req_in.addr == TCC_OFS_RATIO_CTL) begin
         ratio_en_r <= reg_req_in.wdata[TCC_BIT_RATIO_EN];
      end
   end
   rd_answer_a: assert property (reg_req_in.rd |=> reg_rsp_out.rvalid)
      else $error("read not answered");
   slow_trim_a: assert property (reg_req_in.wr && reg_req_in.addr == TCC_OFS_SLOW_TRIM |=>
      slow_trim_out == $past(reg_req_in.wdata[5:0]))
      else $error("slow trim not applied");
   fast_trim_a: assert property (reg_req_in.wr && reg_req_in.addr == TCC_OFS_FAST_TRIM |=>
      fast_trim_out == $past(reg_req_in.wdata[7:0]))
      else $error("fast trim not applied");
   apwr_field_a: assert property (apwr_wr |->
      ##2 afe_ctrl_out.field == $past(reg_req_in.wdata[8:3], 2))
      else $error("analog power field wrong");
   single_chan_a: assert property (apwr_wr |-> ##2 afe_ctrl_out.single_chan ==
      ($past(reg_req_in.wdata[8:3], 2) == TCC_APWR_SINGLE))
      else $error("single channel decode wrong");
   bpf_off_a: assert property (apwr_wr |-> ##2 afe_ctrl_out.bpf_off ==
      ($past(reg_req_in.wdata[8:3], 2) == TCC_APWR_NO_BPF))
      else $error("filter disable decode wrong");
   ratio_clear_a: assert property (reg_req_in.rd && reg_req_in.addr == TCC_OFS_RATIO &&
      !ratio_en_r |=> reg_rsp_out.rdata == 16'h0000)
      else $error("ratio not cleared");
   int_cause_a: assert property ($rose(int_out) |->
      (sample_a_out && !mask_r[TCC_BIT_MASK_A]) || (sample_b_out && !mask_r[TCC_BIT_MASK_B]))
      else $error("interrupt without unmasked sample");
   int_unmasked_a: assert property (sample_a_out && !mask_r[TCC_BIT_MASK_A] |-> int_out)
      else $error("unmasked sample gave no interrupt");
   int_unmasked_b_a: assert property (sample_b_out && !mask_r[TCC_BIT_MASK_B] |-> int_out)
      else $error("unmasked slot B sample gave no interrupt");
   slot_exclusive_a: assert property (!(led_a_out && led_b_out))
      else $error("both slot emitters on");
   cover property (sample_a_out && int_out);
   cover property ($rose(led_a_out));
   cover property (afe_ctrl_out.single_chan);
   cover property (afe_ctrl_out.bpf_off);
endmodule : tcc_timing_core_properties

bind tcc_timing_core tcc_timing_core_properties #(.INT_PULSE_CYC(INT_PULSE_CYC)) u_props (
   .core_clk_in(core_clk_in), .rstn_in(rstn_in), .reg_req_in(reg_req_in),
   .reg_rsp_out(reg_rsp_out), .slow_osc_in(slow_osc_in), .fast_osc_in(fast_osc_in),
   .slow_trim_out(slow_trim_out), .fast_trim_out(fast_trim_out), .led_a_out(led_a_out),
   .led_b_out(led_b_out), .sample_a_out(sample_a_out), .sample_b_out(sample_b_out),
   .int_out(int_out), .afe_ctrl_out(afe_ctrl_out)
);

//--- tb/tcc_timing_core_test.sv
// Self-checking bench for the timing core.
`timescale 1ns/1ns
module tcc_timing_core_test;
   import tcc_pkg::*;
   typedef struct {int exp; int aux;} tcc_note_t;
   localparam int SLOW_CYC  = 4000;
   localparam int RATIO_NOM = 2000;
   localparam logic [7:0]  ACC_EN_ADR = 8'h5F; // Access enable sits outside this block.
   localparam logic [7:0]  RST_ADR[11] = '{8'h01, 8'h0A, 8'h12, 8'h15, 8'h31, 8'h36, 8'h3C,
                                           8'h4B, 8'h4D, 8'h50, 8'h77};
   localparam logic [15:0] RST_VAL[11] = '{16'hFFFF, 16'h0000, 16'h0020, 16'h0000, 16'h0104,
                                           16'h0104, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
                                           16'h0000};
   localparam logic [5:0]  APWR[3] = '{6'h38, 6'h12, 6'h00};
   logic          core_clk_in = 1'b0;
   logic          rstn_in = 1'b0;
   logic          slow_osc = 1'b0;
   logic          fast_osc = 1'b0;
   tcc_reg_req_t  req = '0;
   tcc_reg_rsp_t  rsp;
   tcc_afe_ctrl_t afe;
   logic          led_a, samp_a, intr;
   logic          led_q = 1'b0;
   logic          int_exp = 1'b0;
   logic [15:0]   rnd;
   int            num_errors = 0, compares = 0, cyc = 0, last_a = 0, pulses = 0, osc_cnt = 0;
   tcc_note_t     rd_q[$], samp_q[$];

   tcc_timing_core #(.INT_PULSE_CYC(2)) dut (
      .core_clk_in(core_clk_in), .rstn_in(rstn_in), .reg_req_in(req), .reg_rsp_out(rsp),
      .slow_osc_in(slow_osc), .fast_osc_in(fast_osc), .slow_trim_out(), .fast_trim_out(),
      .led_a_out(led_a), .led_b_out(), .sample_a_out(samp_a), .sample_b_out(),
      .int_out(intr), .afe_ctrl_out(afe)
   );

   initial begin
      forever #4 core_clk_in = ~core_clk_in;
   end
   // Oscillators step off the core clock; two slow periods span 2000 fast periods.
   always @(posedge core_clk_in) begin
      osc_cnt <= (osc_cnt + 1) % SLOW_CYC;
      if (osc_cnt % 2 == 1) fast_osc <= ~fast_osc;
      if (osc_cnt % (SLOW_CYC / 2) == SLOW_CYC / 2 - 1) slow_osc <= ~slow_osc;
   end

   task automatic check_val(input string what, input logic [31:0] got, input int exp, input int tol);
      compares++;
      if (((got + tol) >= exp && got <= (exp + tol)) !== 1'b1) begin
         num_errors++;
         $display("[FAIL] %0t %s got %0d expected %0d", $time, what, got, exp);
      end
   endtask : check_val

   task automatic reg_wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge core_clk_in);
      req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(posedge core_clk_in);
      req.wr <= 1'b0;
   endtask : reg_wr

   task automatic reg_rd(input logic [7:0] a, input int exp, input int tol = 0);
      rd_q.push_back('{exp, tol});
      @(posedge core_clk_in);
      req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
      @(posedge core_clk_in);
      req.rd <= 1'b0;
   endtask : reg_rd

   // Noting after a strobe keeps a half-configured window out of the check.
   task automatic wait_samp(input int lim);
      int i;
      for (i = 0; i < lim && samp_a !== 1'b1; i++) @(negedge core_clk_in);
      if (i == lim) check_val("sample strobe", 0, 1, 0);
      @(posedge core_clk_in);
      #1;
   endtask : wait_samp

   task automatic end_sim();
      $display("compares %0d mismatches %0d", compares, num_errors);
      if (num_errors == 0 && compares > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : end_sim

   always @(posedge core_clk_in) begin
      tcc_note_t n;
      cyc++;
      if (rsp.rvalid === 1'b1) begin
         if (rd_q.size() == 0) check_val("unexpected read answer", 1, 0, 0);
         else begin
            n = rd_q.pop_front();
            check_val("register read", rsp.rdata, n.exp, n.aux);
         end
      end
      if (led_a === 1'b1 && led_q !== 1'b1) pulses++;
      led_q = led_a;
      if (samp_a === 1'b1) begin
         check_val("interrupt", intr, int_exp, 0);
         if (samp_q.size() > 0) begin
            n = samp_q.pop_front();
            check_val("pulse count", pulses, n.exp, 0);
            check_val("sample period", cyc - last_a, n.aux, 4);
         end
         pulses = 0;
         last_a = cyc;
      end
   end

   initial begin
      repeat (100000) @(posedge core_clk_in);
      num_errors++;
      $display("[FAIL] %0t watchdog expired", $time);
      end_sim();
   end

   initial begin
      void'($urandom(25061));
      repeat (10) @(posedge core_clk_in);
      rstn_in <= 1'b1;
      foreach (RST_ADR[i]) reg_rd(RST_ADR[i], RST_VAL[i]);
      reg_wr(TCC_OFS_RATIO, 16'h1234);
      reg_rd(TCC_OFS_RATIO, 0);
      $display("reset and map test done");
      repeat (4) begin
         rnd = 16'($urandom());
         reg_wr(TCC_OFS_SLOW_TRIM, rnd);
         reg_rd(TCC_OFS_SLOW_TRIM, rnd);
         reg_wr(TCC_OFS_FAST_TRIM, ~rnd);
         reg_rd(TCC_OFS_FAST_TRIM, 16'(~rnd));
      end
      foreach (APWR[i]) begin
         reg_wr(TCC_OFS_APWR, {7'h00, APWR[i], 3'h0});
         reg_rd(TCC_OFS_APWR, {7'h00, APWR[i], 3'h0});
      end
      $display("trim and power test done");
      reg_wr(ACC_EN_ADR, 16'h0001);
      reg_rd(ACC_EN_ADR, 0);
      for (int k = 0; k < 2; k++) begin
         reg_wr(TCC_OFS_RATIO_CTL, 16'h0020);
         repeat (3 * SLOW_CYC + 40) @(posedge core_clk_in);
         reg_rd(TCC_OFS_RATIO, RATIO_NOM, 2);
         repeat (SLOW_CYC) @(posedge core_clk_in);
         reg_rd(TCC_OFS_RATIO, RATIO_NOM, 2);
         reg_wr(TCC_OFS_RATIO_CTL, 16'h0000);
         reg_rd(TCC_OFS_RATIO, 0);
      end
      reg_wr(ACC_EN_ADR, 16'h0000);
      $display("ratio test done");
      reg_wr(TCC_OFS_INT_MASK, 16'h0000);
      int_exp = 1'b1;
      reg_wr(TCC_OFS_SAMP_FREQ, 16'h0001);
      for (int k = 0; k < 2; k++) begin
         reg_wr(TCC_OFS_AVG, 16'(k << TCC_AVG_A_LSB));
         reg_wr(TCC_OFS_PULSE_A, {8'(3 + 2 * k), 8'h02});
         wait_samp(4 * SLOW_CYC);
         samp_q.push_back('{(3 + 2 * k) << k, SLOW_CYC << k});
         wait_samp(4 * SLOW_CYC);
      end
      reg_wr(TCC_OFS_INT_MASK, 16'h0060);
      int_exp = 1'b0;
      wait_samp(4 * SLOW_CYC);
      $display("sample test done");
      end_sim();
   end
endmodule : tcc_timing_core_test
